// ==== logic/lcd_dispmem.sv ====
// Purpose: Display memory, 160 words of four bits.
// Assumes: Single writer; contents carry no reset.
// Notes: The whole array is also offered flat to the segment decoder.
module lcd_dispmem
    import lcd_pkg::*;
(
    input wire logic clock,
    input wire logic we,
    input wire logic [lcd_pkg::MEM_AW-1:0] waddr,
    input wire logic [lcd_pkg::MEM_DW-1:0] wdata,
    input wire logic [lcd_pkg::MEM_AW-1:0] raddr,
    output logic [lcd_pkg::MEM_DW-1:0] rdata_q,
    output logic [lcd_pkg::MEM_DEPTH*lcd_pkg::MEM_DW-1:0] flat
);
    logic [MEM_DW-1:0] mem_q [MEM_DEPTH];

    // no reset
    // Undefined after reset, so software must fill it first.
    // read and write
    always_ff @(posedge clock) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
        rdata_q <= mem_q[raddr];
    end

    genvar i;
    generate
        for (i = 0; i < MEM_DEPTH; i++) begin : g_flat
            assign flat[i*MEM_DW +: MEM_DW] = mem_q[i];
        end
    endgenerate
endmodule

// ==== logic/lcd_frame_gen.sv ====
// Purpose: Common scan timing from the low-speed oscillator rate.
// Assumes: clock at 25 MHz; one oscillator tick every OSC_DIV cycles.
// Notes: Duty changes take effect at once, including the length of the current half slot.
module lcd_frame_gen
    import lcd_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] duty,
    output logic [2:0] com_idx_q,
    output logic phase_q
);
    logic [9:0] div_q, div_d;
    logic [7:0] half_q, half_d;
    logic [2:0] com_idx_d;
    logic phase_d;
    logic osc_tick;
    logic [7:0] half_len;
    logic [2:0] last_com;

    always_comb begin
        if (duty[1]) begin
            half_len = 8'(HALF_8);
            last_com = 3'h7;
        end else if (duty == DUTY_5) begin
            half_len = 8'(HALF_5);
            last_com = 3'h4;
        end else begin
            half_len = 8'(HALF_4);
            last_com = 3'h3;
        end
    end

    always_comb begin
        osc_tick = (div_q == 10'(OSC_DIV - 1));
        div_d = osc_tick ? 10'h000 : div_q + 10'h001;
        half_d = half_q;
        phase_d = phase_q;
        com_idx_d = com_idx_q;
        if (osc_tick) begin
            if (half_q >= half_len - 8'h01) begin
                half_d = 8'h00;
                phase_d = ~phase_q;
                if (phase_q) begin
                    com_idx_d = (com_idx_q >= last_com) ? 3'h0
                                                        : com_idx_q + 3'h1;
                end
            end else begin
                half_d = half_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 10'h000;
            half_q <= 8'h00;
            phase_q <= 1'b0;
            com_idx_q <= 3'h0;
        end else begin
            div_q <= div_d;
            half_q <= half_d;
            phase_q <= phase_d;
            com_idx_q <= com_idx_d;
        end
    end
endmodule

// ==== logic/lcd_pkg.sv ====
// Purpose: Shared constants, types and build options of the segment panel
//          driver.
// Assumes: One 25 MHz clock; the low-speed oscillator rate is derived by an
//          enable divider.
// Notes on behaviour
// - Eight commons and sixty-four segments address up to 512 segments.
// - Dynamic drive uses one-third bias, three levels, 1/4, 1/5, 1/8 duty.
// - Power bit set supplies drive levels; cleared, levels sit at ground.
// - DC segment lines act as plain port pins, ignoring the power bit.
// - All-on forces on waveforms, all-off forces off; both clear is normal.
// - All-on wins when both override bits are set.
// - Duty high bit selects 1/8; 01 selects 1/5; 00 selects 1/4.
// - Frame rate is 32 Hz, 40 Hz, 32 Hz for 1/8, 1/5, 1/4.
// - Static select works only with the external half-bias supply option.
// - Static segment is on when any of its eight common bits is one.
// - Display memory spans indices F000H to F09FH; one lights the segment.
// - Display memory is read/write; unmapped words are general storage.
// - A build-time decoder maps any memory bit to any segment and common.
// - Segment pairs 2n, 2n+1 may be DC outputs of the common-zero bit.
// - Each DC segment is built as push-pull or open-drain.
package lcd_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int OSC_HZ = 32_768;
    localparam int OSC_DIV = (CLK_HZ + OSC_HZ / 2) / OSC_HZ;
    localparam int FRAME_HZ_8 = 32;
    localparam int FRAME_HZ_5 = 40;
    localparam int FRAME_HZ_4 = 32;
    // Each common slot is two halves of opposite polarity, so no DC bias.
    localparam int HALF_8 = OSC_HZ / (FRAME_HZ_8 * 8 * 2);
    localparam int HALF_5 = OSC_HZ / (FRAME_HZ_5 * 5 * 2);
    localparam int HALF_4 = OSC_HZ / (FRAME_HZ_4 * 4 * 2);
    localparam int N_COM = 8;
    localparam int N_SEG = 64;
    localparam int N_PAIR = N_SEG / 2;
    localparam int MEM_DEPTH = 160;
    localparam int MEM_AW = 8;
    localparam int MEM_DW = 4;
    localparam int ADDR_W = 18;
    localparam logic [15:0] MEM_FIRST_IDX = 16'hf000;
    localparam logic [15:0] MEM_LAST_IDX = 16'hf09f;
    localparam logic [ADDR_W-1:0] MEM_FIRST_ADDR = {MEM_FIRST_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] MEM_LAST_ADDR = {MEM_LAST_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 18'h00000;
    localparam logic [ADDR_W-1:0] OVR_ADDR = 18'h00004;
    localparam logic [ADDR_W-1:0] STAT_ADDR = 18'h00008;
    localparam int CTRL_PWR_BIT = 0;
    localparam int CTRL_STATIC_BIT = 1;
    localparam int CTRL_DUTY_LO_BIT = 2;
    localparam int CTRL_DUTY_HI_BIT = 3;
    localparam int OVR_ON_BIT = 1;
    localparam int OVR_OFF_BIT = 2;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [3:0] OVR_RST = 4'h4;
    localparam logic [1:0] DUTY_4 = 2'h0;
    localparam logic [1:0] DUTY_5 = 2'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef logic [1:0] lcd_level_t;
    localparam lcd_level_t LVL_VSS = 2'h0;
    localparam lcd_level_t LVL_V1 = 2'h1;
    localparam lcd_level_t LVL_V2 = 2'h2;
    localparam lcd_level_t LVL_V3 = 2'h3;
    typedef enum logic [1:0] {
        SUP_INTERNAL = 2'b00,
        SUP_EXT_THIRD_HI = 2'b01,
        SUP_EXT_THIRD_LO = 2'b10,
        SUP_EXT_HALF = 2'b11
    } lcd_supply_e;
    localparam lcd_supply_e SUPPLY_OPT = SUP_INTERNAL;
    localparam logic [N_PAIR-1:0] DC_PAIR_MASK = 32'h0000_0000;
    localparam logic [N_SEG-1:0] OPEN_DRAIN_MASK = 64'h0000_0000_0000_0000;
    // Build-time segment map: flat memory bit index is word * 4 + data bit.
    function automatic int lcd_map_bit(input int seg, input int com);
        return seg * N_COM + com;
    endfunction
endpackage

// ==== logic/lcd_top.sv ====
// Purpose: Segment panel driver with AXI4-Lite register and memory access.
// Assumes: One clock; panel levels are 2-bit codes for an analog driver.
// Notes: Level codes 0..3 select ground, first, second and third level.
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
module lcd_top
    import lcd_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [lcd_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [lcd_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [lcd_pkg::N_COM*2-1:0] common_lines,
    output logic [lcd_pkg::N_SEG*2-1:0] segment_lines,
    output logic [lcd_pkg::N_SEG-1:0] segment_dc_o,
    output logic [lcd_pkg::N_SEG-1:0] segment_dc_oe_n,
    output logic bias_supply_on
);
    import lcd_pkg::*;

    logic [3:0] ctrl_q, ctrl_d;
    logic [3:0] ovr_q, ovr_d;
    logic aw_full_q, aw_full_d;
    logic w_full_q, w_full_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [3:0] wdata_q, wdata_d;
    logic wstrb0_q, wstrb0_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rd_wait_q, rd_wait_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic [ADDR_W-1:0] araddr_q, araddr_d;
    logic [2:0] com_idx;
    logic phase;
    logic mem_we;
    logic [MEM_AW-1:0] mem_waddr;
    logic [MEM_AW-1:0] mem_raddr;
    logic [MEM_DW-1:0] mem_rdata;
    logic [MEM_DEPTH*MEM_DW-1:0] mem_flat;
    logic do_write;
    logic w_is_mem;
    logic ar_take;
    logic [1:0] duty;
    logic pwr_on;
    logic static_mode;
    logic force_on;
    logic force_off;
    logic [2:0] last_com;

    lcd_dispmem u_mem (
        .clock(clock),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(wdata_q),
        .raddr(mem_raddr),
        .rdata_q(mem_rdata),
        .flat(mem_flat)
    );

    lcd_frame_gen u_frame (
        .clock(clock),
        .rst_n(rst_n),
        .duty(duty),
        .com_idx_q(com_idx),
        .phase_q(phase)
    );

    assign duty = {ctrl_q[CTRL_DUTY_HI_BIT], ctrl_q[CTRL_DUTY_LO_BIT]};
    assign last_com = duty[1] ? 3'h7 : (duty == DUTY_5 ? 3'h4 : 3'h3);
    assign pwr_on = ctrl_q[CTRL_PWR_BIT];
    assign bias_supply_on = pwr_on;
    // static gating
    // Under any other supply the bit is stored but has no effect.
    assign static_mode = ctrl_q[CTRL_STATIC_BIT]
                         && (SUPPLY_OPT == SUP_EXT_HALF);
    assign force_on = ovr_q[OVR_ON_BIT];
    assign force_off = ovr_q[OVR_OFF_BIT] && !force_on;

    // Write channel: address and data are taken independently, in any order.
    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready = !w_full_q && !bvalid_q;
    assign do_write = aw_full_q && w_full_q && !bvalid_q;
    assign w_is_mem = (awaddr_q >= MEM_FIRST_ADDR)
                      && (awaddr_q <= MEM_LAST_ADDR)
                      && (awaddr_q[1:0] == 2'h0);
    assign mem_waddr = MEM_AW'((awaddr_q - MEM_FIRST_ADDR) >> 2);
    assign mem_we = do_write && w_is_mem && wstrb0_q;

    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb0_d = wstrb0_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        ctrl_d = ctrl_q;
        ovr_d = ovr_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_d = 1'b1;
            wdata_d = s_axi_wdata[3:0];
            wstrb0_d = s_axi_wstrb[0];
        end
        if (do_write) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            if (awaddr_q == CTRL_ADDR) begin
                if (wstrb0_q) begin
                    ctrl_d = wdata_q;
                end
            end else if (awaddr_q == OVR_ADDR) begin
                if (wstrb0_q) begin
                    ovr_d = wdata_q & 4'h6;
                end
            end else if (!w_is_mem) begin
                bresp_d = RESP_SLVERR;
            end
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    // Read channel: one cycle to fetch memory, then the answer is registered.
    assign s_axi_arready = !rd_wait_q && !rvalid_q;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign mem_raddr = MEM_AW'((s_axi_araddr - MEM_FIRST_ADDR) >> 2);

    always_comb begin
        rd_wait_d = rd_wait_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        araddr_d = araddr_q;
        if (ar_take) begin
            rd_wait_d = 1'b1;
            araddr_d = s_axi_araddr;
        end
        if (rd_wait_q) begin
            rd_wait_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = 32'h0000_0000;
            if (araddr_q == CTRL_ADDR) begin
                rdata_d[3:0] = ctrl_q;
            end else if (araddr_q == OVR_ADDR) begin
                rdata_d[3:0] = ovr_q;
            end else if (araddr_q == STAT_ADDR) begin
                rdata_d[3:0] = {phase, com_idx};
            end else if ((araddr_q >= MEM_FIRST_ADDR)
                         && (araddr_q <= MEM_LAST_ADDR)
                         && (araddr_q[1:0] == 2'h0)) begin
                rdata_d[3:0] = mem_rdata;
            end else begin
                rresp_d = RESP_SLVERR;
            end
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
            ovr_q <= OVR_RST;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 4'h0;
            wstrb0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rd_wait_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
            araddr_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            ovr_q <= ovr_d;
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb0_q <= wstrb0_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rd_wait_q <= rd_wait_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            araddr_q <= araddr_d;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Panel waveforms. Phase 0 and phase 1 are opposite halves of each slot.
    // eight commons
    genvar c, s;
    generate
        for (c = 0; c < N_COM; c++) begin : g_com
            logic [1:0] lvl;
            always_comb begin
                if (!pwr_on) begin
                    lvl = LVL_VSS;
                end else if (static_mode) begin
                    lvl = phase ? LVL_VSS : LVL_V3;
                end else if (3'(c) > last_com || 3'(c) != com_idx) begin
                    lvl = phase ? LVL_V2 : LVL_V1;
                end else begin
                    lvl = phase ? LVL_VSS : LVL_V3;
                end
            end
            assign common_lines[c*2 +: 2] = lvl;
        end

        for (s = 0; s < N_SEG; s++) begin : g_seg
            logic [N_COM-1:0] bits;
            logic cur_bit;
            logic seg_on;
            logic is_dc;
            logic [1:0] lvl;
            for (c = 0; c < N_COM; c++) begin : g_map
                assign bits[c] = mem_flat[lcd_map_bit(s, c)];
            end
            assign cur_bit = bits[com_idx];
            assign is_dc = DC_PAIR_MASK[s/2];
            always_comb begin
                seg_on = static_mode ? (|bits) : cur_bit;
                if (force_on) begin
                    seg_on = 1'b1;
                end else if (force_off) begin
                    seg_on = 1'b0;
                end
                if (!pwr_on || is_dc) begin
                    lvl = LVL_VSS;
                end else if (static_mode) begin
                    lvl = (seg_on ^ phase) ? LVL_VSS : LVL_V3;
                end else if (seg_on) begin
                    lvl = phase ? LVL_V3 : LVL_VSS;
                end else begin
                    lvl = phase ? LVL_V1 : LVL_V2;
                end
            end
            assign segment_lines[s*2 +: 2] = lvl;
            assign segment_dc_o[s] = is_dc & bits[0];
            assign segment_dc_oe_n[s] = !is_dc
                                        || (OPEN_DRAIN_MASK[s] && bits[0]);
        end
    endgenerate
endmodule

// ==== verif/lcd_chk_props.sv ====
// Purpose: Port assertions for the segment panel driver.
// Assumes: Internal supply build with no DC pairs.
// Notes: Idle-common and segment level checks apply only in phase 0, found from a common at level 3, so no phase tracking is needed.
module lcd_chk
    import lcd_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [lcd_pkg::N_COM*2-1:0] common_lines,
    input wire logic [lcd_pkg::N_SEG*2-1:0] segment_lines,
    input wire logic [lcd_pkg::N_SEG-1:0] segment_dc_o,
    input wire logic [lcd_pkg::N_SEG-1:0] segment_dc_oe_n,
    input wire logic bias_supply_on
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    function automatic int n_at(input logic [15:0] c, input logic [1:0] v);
        int n;
        n = 0;
        for (int i = 0; i < 8; i++) begin
            if (c[2*i+:2] == v) begin
                n++;
            end
        end
        return n;
    endfunction
    a_pwr_off: assert property (
        !bias_supply_on |-> common_lines == '0 && segment_lines == '0)
        else $error("levels not grounded with power off");
    a_one_sel: assert property (
        bias_supply_on |->
        n_at(common_lines, 2'h0) + n_at(common_lines, 2'h3) == 1)
        else $error("not exactly one common selected");
    a_unsel_lvl: assert property (
        bias_supply_on && n_at(common_lines, 2'h3) == 1 |->
        n_at(common_lines, 2'h1) == 7)
        else $error("idle common not at non-selecting level");
    a_seg_phase: assert property (
        bias_supply_on && n_at(common_lines, 2'h3) == 1 |->
        (segment_lines & {64{2'h1}}) == '0)
        else $error("segment level out of phase");
    a_dc_pins: assert property (
        segment_dc_oe_n == '1 && segment_dc_o == '0)
        else $error("dc pin active without dc pair");
    a_wr_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |-> ##[2:3] s_axi_rvalid)
        else $error("read response late");
    a_wr_block: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_rd_block: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_all_on: cover property (bias_supply_on && segment_lines == '0);
endmodule

bind lcd_top lcd_chk u_lcd_chk (.clock, .rst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .common_lines, .segment_lines, .segment_dc_o,
    .segment_dc_oe_n, .bias_supply_on);

// ==== verif/lcd_panel_model.sv ====
// Purpose: Panel glass model; a cell on common zero lights at full swing.
// Assumes: Level codes are equal steps of one-third bias.
// Notes: Only common zero is modelled, which keeps the bench short.
module lcd_panel_model
    import lcd_pkg::*;
(
    input wire logic [lcd_pkg::N_COM*2-1:0] common_lines,
    input wire logic [lcd_pkg::N_SEG*2-1:0] segment_lines,
    output logic [lcd_pkg::N_SEG-1:0] lit
);
    always_comb begin
        for (int s = 0; s < N_SEG; s++) begin
            lit[s] = (common_lines[1:0] == 2'h3
                      && segment_lines[2*s+:2] == 2'h0)
                || (common_lines[1:0] == 2'h0
                    && segment_lines[2*s+:2] == 2'h3);
        end
    end
endmodule

// ==== verif/tb.sv ====
// Purpose: Self-checking bench for the segment panel driver.
// Assumes: All panel checks fall in the first slot, on common zero.
// Notes: Memory is filled first, since unknown bits would reach the pins.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lcd_pkg::*;
    logic clock, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, bias_supply_on;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] common_lines;
    logic [127:0] segment_lines;
    logic [63:0] segment_dc_o, segment_dc_oe_n, lit;
    int failures, num_checks;
    int cyc;
    localparam logic [127:0] SEG_NORM = {32{4'h2}};
    localparam logic [127:0] COM_PH0 = 128'h5557;
    lcd_top u_lcd_top (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .common_lines,
        .segment_lines, .segment_dc_o, .segment_dc_oe_n, .bias_supply_on);
    lcd_panel_model u_lcd_panel_model (.common_lines, .segment_lines, .lit);
    task automatic chk(input string what, input logic [127:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wchk(input logic [17:0] a, input logic [31:0] d,
                        input logic [1:0] r);
        logic ah, wh, bh;
        logic [1:0] resp;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int i = 0; i < 40; i++) begin
            @(negedge clock);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clock);
            if (ah) s_axi_awvalid <= 1'h0;
            if (wh) s_axi_wvalid <= 1'h0;
            if (bh) begin
                s_axi_bready <= 1'h0;
                break;
            end
        end
        chk("bresp", 128'(resp), 128'(r));
    endtask
    task automatic rchk(input logic [17:0] a, input logic [3:0] d,
                        input logic [1:0] r);
        logic ah, rh;
        logic [31:0] got;
        logic [1:0] resp;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int i = 0; i < 40; i++) begin
            @(negedge clock);
            ah = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rvalid;
            got = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clock);
            if (ah) s_axi_arvalid <= 1'h0;
            if (rh) begin
                s_axi_rready <= 1'h0;
                break;
            end
        end
        chk("rdata", 128'(got), 128'(d));
        chk("rresp", 128'(resp), 128'(r));
    endtask
    function automatic logic [17:0] maddr(input int i);
        return MEM_FIRST_ADDR + 18'(i * 4);
    endfunction
    task automatic t_reset();
        @(negedge clock);
        chk("bias", 128'(bias_supply_on), 128'h0);
        chk("com levels", 128'(common_lines), 128'h0);
        chk("seg levels", segment_lines, 128'h0);
        rchk(CTRL_ADDR, 4'h0, RESP_OKAY);
        rchk(OVR_ADDR, 4'h4, RESP_OKAY);
    endtask
    task automatic t_mem();
        // Odd segments end up lit on common zero with this pattern.
        for (int i = 0; i < 160; i++) begin
            wchk(maddr(i), 32'(4'(i >> 1) ^ 4'ha), RESP_OKAY);
        end
        rchk(maddr(0), 4'ha, RESP_OKAY);
        rchk(maddr(101), 4'h8, RESP_OKAY);
        rchk(MEM_LAST_ADDR, 4'h5, RESP_OKAY);
        wchk(18'h0000c, 32'hf, RESP_SLVERR);
        rchk(18'h0000c, 4'h0, RESP_SLVERR);
    endtask
    task automatic t_drive();
        wchk(OVR_ADDR, 32'h0, RESP_OKAY);
        wchk(CTRL_ADDR, 32'h9, RESP_OKAY);
        @(negedge clock);
        chk("bias", 128'(bias_supply_on), 128'h1);
        chk("com", 128'(common_lines), COM_PH0);
        chk("seg", segment_lines, SEG_NORM);
        chk("lit", 128'(lit), 128'({32{2'h2}}));
    endtask
    task automatic t_ovr();
        logic [3:0] v;
        logic [127:0] es;
        for (int k = 0; k < 4; k++) begin
            v = 4'(k * 2 + 2) & 4'h6;
            es = v[1] ? 128'h0 : (v[2] ? {64{2'h2}} : SEG_NORM);
            wchk(OVR_ADDR, 32'(v), RESP_OKAY);
            rchk(OVR_ADDR, v, RESP_OKAY);
            @(negedge clock);
            chk("ovr seg", segment_lines, es);
        end
    endtask
    task automatic t_duty();
        for (int d = 0; d < 4; d++) begin
            wchk(CTRL_ADDR, 32'(d * 4 + 1), RESP_OKAY);
            rchk(CTRL_ADDR, 4'(d * 4 + 1), RESP_OKAY);
            @(negedge clock);
            chk("duty com", 128'(common_lines), COM_PH0);
        end
        wchk(CTRL_ADDR, 32'hb, RESP_OKAY);
        @(negedge clock);
        chk("static com", 128'(common_lines), COM_PH0);
        chk("static seg", segment_lines, SEG_NORM);
    endtask
    task automatic t_frame();
        // Waits in 1/8 duty for the first phase flip of common zero.
        while (common_lines === 16'h5557
               && cyc < 2 * HALF_8 * OSC_DIV) begin
            @(negedge clock);
        end
        chk("half slot", 128'(cyc), 128'(HALF_8 * OSC_DIV));
        chk("com ph1", 128'(common_lines), 128'haaa8);
        chk("seg ph1", segment_lines, {32{4'hd}});
        chk("lit ph1", 128'(lit), 128'({32{2'h2}}));
    endtask
    task automatic t_off();
        wchk(CTRL_ADDR, 32'h0, RESP_OKAY);
        @(negedge clock);
        chk("off com", 128'(common_lines), 128'h0);
        chk("off seg", segment_lines, 128'h0);
        chk("dc data", 128'(segment_dc_o), 128'h0);
        chk("dc oe", 128'(segment_dc_oe_n), 128'({64{1'h1}}));
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end
    // Counts edges since reset release, for the frame timing check.
    always @(posedge clock) begin
        if (rst_n) begin
            cyc <= cyc + 1;
        end
    end
    initial begin
        repeat (60000) @(posedge clock);
        failures++;
        finish_test();
    end
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 18'h0;
        s_axi_araddr = 18'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (10) @(posedge clock);
        rst_n <= 1'h1;
        t_reset();
        t_mem();
        t_drive();
        t_ovr();
        t_duty();
        t_frame();
        t_off();
        finish_test();
    end
endmodule
